/* File: design/sac_consts.svh */
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define SAC_ADDR_CTRL     4'h0
`define SAC_ADDR_RESULT   4'h4
`define SAC_ADDR_STATUS   4'h8
`define SAC_ADDR_IMASK    4'hc

// ****************************************
// control register fields and reset
// ****************************************
`define SAC_CTRL_MASK_BIT  7
`define SAC_CTRL_DONE_BIT  6
`define SAC_CTRL_GO_BIT    5
`define SAC_CTRL_POWER_BIT 4
`define SAC_CTRL_RESET     8'h40

// ****************************************
// status / interrupt mask fields
// ****************************************
`define SAC_EVT_DONE_BIT    0
`define SAC_EVT_RESTART_BIT 1
`define SAC_EVT_WIDTH       2

// ****************************************
// conversion timing
// ****************************************
`define SAC_OSC_KHZ       8000
`define SAC_CONV_TIME_NS  70000
`define SAC_CLK_DIV       12
`define SAC_CONV_TICKS    ((`SAC_CONV_TIME_NS * `SAC_OSC_KHZ) / (`SAC_CLK_DIV * 1000000))
`define SAC_RES_BITS      8
`define SAC_BIT_TICKS     5
`define SAC_SETTLE_TICKS  (`SAC_CONV_TICKS - `SAC_RES_BITS * `SAC_BIT_TICKS)

`endif

/* File: design/sac_pkg.sv */
package sac_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SETTLE,
    SAC_APPROX
  } sac_state_e;

  typedef struct packed {
    logic mask;
    logic done;
    logic power;
  } sac_ctrl_s;

  typedef struct packed {
    logic       read;
    logic       write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [7:0] writedata;
  } sac_req_s;

endpackage

/* File: design/sac_tick_div.sv */
`timescale 1ns/1ps
`default_nettype none

module sac_tick_div #(
  parameter int DIV = 12
) (
  input  wire logic core_clk_i, // system clock
  input  wire logic sys_rst_i,  // sync reset, active high
  input  wire logic clr_i,      // restart the division phase
  output logic      tick_o      // one-cycle pulse every DIV clocks
);

  logic [$clog2(DIV)-1:0] cnt;

  // restart aligns the first tick exactly DIV cycles after a start
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || clr_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (cnt == $bits(cnt)'(DIV - 1)) begin
      cnt    <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule // sac_tick_div

`default_nettype wire

/* File: design/sac_top.sv */
// Function
// - go write starts conversion, clears done
// - finished conversion sets done flag
// - one conversion per go write
// - go while busy restarts conversion
// - go bit always reads zero
// - done raises end-of-conversion interrupt
// - interrupt gated by control mask bit
// - power bit low keeps converter down
// - reset aborts, control becomes 40h
// - 8-bit successive approximation, clock/12 steps
// - conversion lasts 46 ticks, 552 clocks or 69us at 8MHz
// - result held until next conversion ends
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"

module sac_top #(
  parameter int DIV        = `SAC_CLK_DIV,
  parameter int BIT_TICKS  = `SAC_BIT_TICKS,
  parameter int SETTLE_TKS = `SAC_SETTLE_TICKS
) (
  input  wire logic        core_clk_i,    // 8 MHz clock
  input  wire logic        sys_rst_i,     // sync reset, active high
  input  wire logic [3:0]  address_i,     // avalon byte address
  input  wire logic        read_i,        // avalon read
  input  wire logic        write_i,       // avalon write
  input  wire logic [3:0]  byteenable_i,  // avalon byte enables
  input  wire logic [31:0] writedata_i,   // avalon write data
  output logic [31:0]      readdata_o,    // avalon read data
  output logic             waitrequest_o, // avalon wait
  input  wire logic        cmp_i,         // comparator: input >= trial
  output logic [7:0]       trial_code_o,  // trial code to the dac
  output logic             power_on_o,    // analog front end powered
  output logic             busy_o,        // conversion running
  output logic             irq_o          // end-of-conversion request
);

  // ****************************************
  // bus request
  // ****************************************
  sac_pkg::sac_req_s req;
  logic              acc;
  logic              wr_acc;
  logic              rd_acc;
  logic              be0;

  assign req = '{read: read_i, write: write_i, address: address_i,
                 byteenable: byteenable_i, writedata: writedata_i[7:0]};
  assign acc    = (req.read || req.write) && !waitrequest_o;
  assign wr_acc = acc && req.write;
  assign rd_acc = acc && req.read;
  assign be0    = req.byteenable[0];

  // ****************************************
  // state
  // ****************************************
  localparam logic [7:0]         CTRL_RST = `SAC_CTRL_RESET;
  sac_pkg::sac_ctrl_s            ctrl;
  sac_pkg::sac_state_e           state;
  logic [7:0]                    result;
  logic [7:0]                    trial;
  logic [2:0]                    bit_idx;
  logic [5:0]                    tick_cnt;
  logic [`SAC_EVT_WIDTH-1:0]     status;
  logic [`SAC_EVT_WIDTH-1:0]     imask;
  logic [`SAC_EVT_WIDTH-1:0]     next_status;
  logic                          tick;
  logic                          start;
  logic                          finish;
  logic                          restart;
  logic                          next_power;
  logic                          cmp_s1;
  logic                          cmp_s2;
  logic                          cmp_s3;
  logic                          cmp_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // power as it will stand after this cycle's write
  assign next_power = (wr_acc && be0 && hit(req.address, `SAC_ADDR_CTRL))
                      ? req.writedata[`SAC_CTRL_POWER_BIT] : ctrl.power;

  // go is sampled on every accepted control write with byte 0 enabled, busy or not
  assign start = wr_acc && be0 && hit(req.address, `SAC_ADDR_CTRL)
                 && req.writedata[`SAC_CTRL_GO_BIT];
  assign restart = start && (state != sac_pkg::SAC_IDLE);

  // an abandoned conversion never finishes
  assign finish = !start && ctrl.power && tick && state == sac_pkg::SAC_APPROX
                  && tick_cnt == 6'(BIT_TICKS - 1) && bit_idx == 3'h0;

  // ****************************************
  // conversion clock
  // ****************************************
  sac_tick_div #(
    .DIV (DIV)
  ) u_div (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clr_i      (start),
    .tick_o     (tick)
  );

  // ****************************************
  // comparator synchroniser
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_q  <= 1'b0;
    end else begin
      cmp_s1 <= cmp_i;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_q <= cmp_s3;
      end
    end
  end

  // ****************************************
  // bus handshake
  // ****************************************
  // one wait cycle per access; readdata is loaded as waitrequest drops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= !((req.read || req.write) && waitrequest_o);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (req.read && waitrequest_o) begin
      unique case (req.address)
        `SAC_ADDR_CTRL: begin
          readdata_o <= {24'h00_0000, ctrl.mask, ctrl.done, 1'b0,
                         ctrl.power, 4'h0};
        end
        `SAC_ADDR_RESULT: readdata_o <= {24'h00_0000, result};
        `SAC_ADDR_STATUS: readdata_o <= {30'h0000_0000, status};
        `SAC_ADDR_IMASK:  readdata_o <= {30'h0000_0000, imask};
        default:          readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      {ctrl.mask, ctrl.done, ctrl.power} <=
        {CTRL_RST[`SAC_CTRL_MASK_BIT], CTRL_RST[`SAC_CTRL_DONE_BIT],
         CTRL_RST[`SAC_CTRL_POWER_BIT]};
    end else begin
      if (wr_acc && be0 && hit(req.address, `SAC_ADDR_CTRL)) begin
        ctrl.mask  <= req.writedata[`SAC_CTRL_MASK_BIT];
        ctrl.power <= req.writedata[`SAC_CTRL_POWER_BIT];
      end
      // done is never taken from write data
      if (start) begin
        ctrl.done <= 1'b0;
      end else if (finish) begin
        ctrl.done <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      imask <= '0;
    end else if (wr_acc && be0 && hit(req.address, `SAC_ADDR_IMASK)) begin
      imask <= req.writedata[`SAC_EVT_WIDTH-1:0];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // powering down mid-conversion abandons it; done stays clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state    <= sac_pkg::SAC_IDLE;
      tick_cnt <= 6'h00;
      bit_idx  <= 3'h7;
      trial    <= 8'h00;
    end else if (start && next_power) begin
      state    <= sac_pkg::SAC_SETTLE;
      tick_cnt <= 6'h00;
      bit_idx  <= 3'h7;
      trial    <= 8'h00;
    end else if (start || !ctrl.power) begin
      state    <= sac_pkg::SAC_IDLE;
      tick_cnt <= 6'h00;
    end else if (tick) begin
      unique case (state)
        sac_pkg::SAC_IDLE: begin
          state <= sac_pkg::SAC_IDLE;
        end
        sac_pkg::SAC_SETTLE: begin
          if (tick_cnt == 6'(SETTLE_TKS - 1)) begin
            state    <= sac_pkg::SAC_APPROX;
            tick_cnt <= 6'h00;
            trial    <= 8'h80;
          end else begin
            tick_cnt <= tick_cnt + 6'h01;
          end
        end
        sac_pkg::SAC_APPROX: begin
          if (tick_cnt == 6'(BIT_TICKS - 1)) begin
            tick_cnt <= 6'h00;
            trial[bit_idx] <= cmp_q;
            if (bit_idx == 3'h0) begin
              state <= sac_pkg::SAC_IDLE;
            end else begin
              trial[bit_idx - 3'h1] <= 1'b1;
              bit_idx <= bit_idx - 3'h1;
            end
          end else begin
            tick_cnt <= tick_cnt + 6'h01;
          end
        end
      endcase
    end
  end

  // result is loaded only by a finished conversion
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      result <= 8'h00;
    end else if (finish) begin
      result <= {trial[7:1], cmp_q};
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // only bits already reported are cleared, so a later event survives
  always_comb begin
    next_status = status;
    if (rd_acc && hit(req.address, `SAC_ADDR_STATUS)) begin
      next_status = status & ~readdata_o[`SAC_EVT_WIDTH-1:0];
    end
    if (finish) begin
      next_status[`SAC_EVT_DONE_BIT] = 1'b1;
    end
    if (restart) begin
      next_status[`SAC_EVT_RESTART_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status <= '0;
      irq_o  <= 1'b0;
    end else begin
      status <= next_status;
      irq_o  <= ctrl.mask && |(next_status & imask);
    end
  end

  // ****************************************
  // analog-side outputs
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      power_on_o   <= 1'b0;
      busy_o       <= 1'b0;
      trial_code_o <= 8'h00;
    end else begin
      power_on_o   <= ctrl.power;
      busy_o       <= (state != sac_pkg::SAC_IDLE);
      trial_code_o <= trial;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] chk_ticks;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || start) begin
      chk_ticks <= 6'h00;
    end else if (tick && state != sac_pkg::SAC_IDLE) begin
      chk_ticks <= chk_ticks + 6'h01;
    end
  end

  AST_GO_READS_ZERO: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rd_acc && hit(req.address, `SAC_ADDR_CTRL) |-> !readdata_o[`SAC_CTRL_GO_BIT])
    else $error("go bit read back as one");

  AST_START_CLEARS_DONE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    start && next_power |=> !ctrl.done && state == sac_pkg::SAC_SETTLE)
    else $error("start did not clear done or begin conversion");

  AST_RESTART_ABANDONS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    restart && next_power |=> tick_cnt == 6'h00 && state == sac_pkg::SAC_SETTLE)
    else $error("restart did not begin a fresh conversion");

  AST_DONE_ON_FINISH: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    finish |=> ctrl.done && result[7:1] == $past(trial[7:1]) &&
    result[0] == $past(cmp_q))
    else $error("done not set after conversion");

  AST_NO_SELF_START: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state == sac_pkg::SAC_IDLE && !start |=> state == sac_pkg::SAC_IDLE)
    else $error("conversion began without a go write");

  AST_IRQ_ON_DONE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    finish && ctrl.mask && imask[`SAC_EVT_DONE_BIT] && !(wr_acc && be0)
    |=> irq_o && status[`SAC_EVT_DONE_BIT])
    else $error("done did not raise the interrupt");

  AST_IRQ_MASKED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !ctrl.mask |=> !irq_o)
    else $error("interrupt raised while masked");

  AST_POWER_DOWN_IDLE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !ctrl.power && !start |=> state == sac_pkg::SAC_IDLE ##1 !busy_o)
    else $error("converter ran while powered down");

  AST_RESET_LOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> ctrl.done && !ctrl.mask && !ctrl.power
    && state == sac_pkg::SAC_IDLE)
    else $error("reset did not load control register");

  AST_CONV_LENGTH: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    finish |-> chk_ticks == 6'(`SAC_CONV_TICKS - 1))
    else $error("conversion length wrong");

  AST_RESULT_HOLD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !finish |=> $stable(result))
    else $error("result changed without a finished conversion");

  COV_CONVERSION: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    finish ##1 ctrl.done);
  COV_RESTART: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    restart && next_power);
  COV_IRQ: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(irq_o));
  COV_STATUS_CLEAR: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rd_acc && hit(req.address, `SAC_ADDR_STATUS) && |status);

endmodule // sac_top

`default_nettype wire

/* File: bench/sac_cmp_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// comparator on the one selected analog pin
// ****************************************
module sac_cmp_model (
  input  wire logic       core_clk_i, // clock for idle pattern and lag
  input  wire logic       power_i,    // front end powered
  input  wire logic       slow_i,     // answer one clock late
  input  wire logic [7:0] trial_i,    // trial code from the dac
  input  wire logic [7:0] level_i,    // voltage of the single pin
  output logic            cmp_o       // 1 when level >= trial
);
  logic fast;
  logic late  = 1'b0;
  logic junk  = 1'b0;

  assign fast = (level_i >= trial_i);

  always @(posedge core_clk_i) begin
    late <= fast;
    junk <= ~junk;
  end

  // unpowered comparator output is meaningless, so it wobbles
  assign cmp_o = !power_i ? junk : (slow_i ? late : fast);
endmodule // sac_cmp_model

`default_nettype wire

/* File: bench/sar_converter_control_test.sv */
`timescale 1ns/1ps
`default_nettype none

module sar_converter_control_test;
  logic        core_clk_i  = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [3:0]  address_i   = 4'h0;
  logic        read_i      = 1'b0;
  logic        write_i     = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        cmp_i;
  logic [7:0]  trial_code_o;
  logic        power_on_o;
  logic        busy_o;
  logic        irq_o;
  logic [7:0]  level       = 8'h00;
  logic        slow        = 1'b0;
  logic [3:0]  be          = 4'hf;
  logic [7:0]  lv;
  logic [31:0] exp_q[$];
  int          err_count   = 0;
  int          tests_run   = 0;
  int          cycles      = 0;
  int          len;

  always #5 core_clk_i = ~core_clk_i;

  sac_top DUT (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .byteenable_i(be),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .cmp_i(cmp_i), .trial_code_o(trial_code_o),
    .power_on_o(power_on_o), .busy_o(busy_o), .irq_o(irq_o));

  sac_cmp_model PARTNER (
    .core_clk_i(core_clk_i), .power_i(power_on_o), .slow_i(slow),
    .trial_i(trial_code_o), .level_i(level), .cmp_o(cmp_i));

  // ****************************************
  // comparison and closing
  // ****************************************
  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    report(got, exp);
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    report({31'h0, got}, {31'h0, exp});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // read data is taken only at the edge that sees waitrequest low
  always @(posedge core_clk_i) begin
    if (read_i === 1'b1 && waitrequest_o === 1'b0) begin
      if (exp_q.size() == 0) chk_rd(readdata_o, 32'hffff_ffff);
      else chk_rd(readdata_o, exp_q.pop_front());
    end
  end

  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  // ****************************************
  // bus master
  // ****************************************
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    read_i      <= ~wr;
    write_i     <= wr;
    address_i   <= a;
    writedata_i <= {24'h0, d};
    @(posedge core_clk_i);
    while (waitrequest_o !== 1'b0) @(posedge core_clk_i);
    read_i  <= 1'b0;
    write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  // channel settles beyond 26 cycles, then go; len = cycles until idle
  task automatic run_conv(input logic [7:0] v, input logic [7:0] ctl);
    level <= v;
    repeat (30) @(posedge core_clk_i);
    wr(4'h0, ctl | 8'h20);
    rd(4'h0, ctl & 8'h90);
    len = 0;
    while (len < 2000 && (len < 4 || busy_o === 1'b1)) begin
      @(posedge core_clk_i);
      len++;
    end
    chk_pin(len > 540 && len < 560, 1'b1);
    @(posedge core_clk_i);
    rd(4'h4, v);
    rd(4'h0, (ctl & 8'h90) | 8'h40);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hdd2d));
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(4'h0, 8'h40);
    rd(4'hc, 8'h00);
    rd(4'h2, 8'h00);
    chk_pin(power_on_o, 1'b0);
    $display("reset values done");

    wr(4'h0, 8'h10);
    wr(4'hc, 8'h01);
    chk_pin(power_on_o, 1'b1);
    lv = 8'($urandom);
    run_conv(lv, 8'h90);
    chk_pin(irq_o, 1'b1);
    rd(4'h8, 8'h01);
    repeat (2) @(posedge core_clk_i);
    chk_pin(irq_o, 1'b0);
    repeat (60) @(posedge core_clk_i);
    chk_pin(busy_o, 1'b0);
    $display("single conversion done");

    wr(4'h4, ~lv);
    rd(4'h4, lv);
    wr(4'h0, 8'h90);
    rd(4'h0, 8'hd0);
    be <= 4'he;
    wr(4'h0, 8'h00);
    be <= 4'hf;
    rd(4'h0, 8'hd0);
    $display("read-only fields done");

    lv = 8'($urandom);
    level <= lv;
    wr(4'h0, 8'hb0);
    repeat (100) @(posedge core_clk_i);
    run_conv(lv, 8'h90);
    rd(4'h8, 8'h03);
    $display("restart done");

    slow <= 1'b1;
    run_conv(8'hff, 8'h10);
    chk_pin(irq_o, 1'b0);
    rd(4'h8, 8'h01);
    run_conv(8'h00, 8'h10);
    slow <= 1'b0;
    $display("masked interrupt done");

    wr(4'h0, 8'h00);
    @(posedge core_clk_i);
    chk_pin(power_on_o, 1'b0);
    wr(4'h0, 8'h20);
    repeat (20) @(posedge core_clk_i);
    chk_pin(busy_o, 1'b0);
    rd(4'h0, 8'h00);
    $display("power down done");

    wr(4'h0, 8'h10);
    wr(4'h0, 8'hb0);
    repeat (50) @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk_pin(busy_o, 1'b0);
    chk_pin(power_on_o, 1'b0);
    rd(4'h0, 8'h40);
    $display("reset abort done");
    end_of_test();
  end
endmodule // sar_converter_control_test

`default_nettype wire
